// >>> design/dgp_pkg.sv
package dgp_pkg;
  // Peripheral register word and pin count
  localparam int unsigned DGP_DATA_W  = 16;
  localparam int unsigned DGP_ADDR_W  = 16;
  localparam int unsigned DGP_PINS    = 8;
  // Register addresses (word addresses on the peripheral bus)
  localparam logic [15:0] DGP_DIR_ADDR   = 16'h3400;
  localparam logic [15:0] DGP_LEVEL_ADDR = 16'h3401;
  // Reset values
  localparam logic [7:0]  DGP_DIR_RESET  = 8'h00;
  localparam logic [15:0] DGP_RDATA_IDLE = 16'h0000;
  typedef logic [7:0] dgp_pins_t;
endpackage

// >>> design/dgp_pin_if.sv
`timescale 1ns/10ps
// Pin-side signals shared between the register core and the pin stage
interface dgp_pin_if;
  logic [7:0] pin_direction_bit;
  logic [7:0] pin_out_level;
  logic [7:0] pin_sensed;
  modport core (output pin_direction_bit, output pin_out_level, input pin_sensed);
  modport stage (input pin_direction_bit, input pin_out_level, output pin_sensed);
endinterface

// >>> design/dgp_pin_stage.sv
`timescale 1ns/10ps
// Pin drivers and input synchroniser
module dgp_pin_stage
  import dgp_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  // Core side
  dgp_pin_if.stage                 pif,
  // Pads
  input  wire logic [7:0]          pad_in,
  output logic      [7:0]          pad_out,
  output logic      [7:0]          pad_oe
);
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;

  // Two-stage synchroniser, pads are asynchronous to the core clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= DGP_DIR_RESET;
      sync2_reg <= DGP_DIR_RESET;
    end else if (ce) begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Drive only pins set as outputs
  assign pad_oe  = pif.pin_direction_bit;
  assign pad_out = pif.pin_out_level;
  assign pif.pin_sensed = sync2_reg;
endmodule

// >>> design/dgp_gpio_port.sv
`timescale 1ns/10ps
module dgp_gpio_port
  import dgp_pkg::*;
(
  // Clock, enable and reset
  input  wire logic                          core_clk,
  input  wire logic                          core_ce,
  input  wire logic                          rstn,
  // Peripheral bus slave
  input  wire logic [dgp_pkg::DGP_ADDR_W-1:0] pb_addr,
  input  wire logic                          pb_wr,
  input  wire logic                          pb_rd,
  input  wire logic [dgp_pkg::DGP_DATA_W-1:0] pb_wdata,
  output logic      [dgp_pkg::DGP_DATA_W-1:0] pb_rdata,
  output logic                               pb_rvalid,
  // Pins
  input  wire logic [dgp_pkg::DGP_PINS-1:0]   gpio_in,
  output logic      [dgp_pkg::DGP_PINS-1:0]   gpio_out,
  output logic      [dgp_pkg::DGP_PINS-1:0]   gpio_oe
);
  import dgp_pkg::*;

  // Reset release chain
  logic        rst_s1_reg;          // First release stage
  logic        rst_s2_reg;          // Second release stage
  logic        rst_n;               // Released copy used by all core state

  // Register decode
  logic        dir_sel;             // Address points at the direction word
  logic        level_sel;           // Address points at the data word
  logic        dir_wr_en;           // Direction write accepted this cycle
  logic        level_wr_en;         // Data write accepted this cycle
  logic        rd_take;             // Read accepted this cycle

  // Register state
  dgp_pins_t   port_direction_reg;  // One bit per pin, 1 drives the pin
  dgp_pins_t   out_level_reg;       // Level driven on output pins
  dgp_pins_t   wdata_low;           // Meaningful byte of the write word
  dgp_pins_t   level_view;          // Per-pin value seen by a data read

  // Read path
  logic [15:0] rdata_next;          // Word selected by the current address
  logic [15:0] rdata_reg;           // Held answer word
  logic        rvalid_reg;          // Answer flag, one enabled cycle wide

  // Pin-side carrier between core and pin stage
  dgp_pin_if   pif ();

  // Address match shared by read and write paths
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] r);
    addr_hit = (a == r);
  endfunction

  // Widen a pin byte to a bus word; upper bits are always zero
  function automatic logic [15:0] to_word(input dgp_pins_t b);
    to_word = {8'h00, b};
  endfunction

  // Pick per pin between latch and sensed level
  function automatic dgp_pins_t pick_view(input dgp_pins_t dir,
                                          input dgp_pins_t latch,
                                          input dgp_pins_t sensed);
    pick_view = (dir & latch) | (~dir & sensed);
  endfunction

  // Reset release synchroniser, assertion stays asynchronous.
  // Release is delayed two edges so no flop leaves reset on a
  // metastable edge; the clock enable is ignored here on purpose,
  // otherwise a frozen core could never leave reset.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Only the second stage feeds the core
  assign rst_n = rst_s2_reg;

  // Address decode; one match per register
  always_comb begin
    dir_sel   = 1'b0;
    level_sel = 1'b0;
    if (addr_hit(pb_addr, DGP_DIR_ADDR)) begin
      dir_sel = 1'b1;
    end else if (addr_hit(pb_addr, DGP_LEVEL_ADDR)) begin
      level_sel = 1'b1;
    end
  end

  // Strobe qualification; a low enable drops the request entirely
  assign dir_wr_en   = core_ce & pb_wr & dir_sel;
  assign level_wr_en = core_ce & pb_wr & level_sel;
  assign rd_take     = core_ce & pb_rd;

  // Only the low byte carries pin bits; the upper byte is discarded
  assign wdata_low = pb_wdata[7:0];

  // Direction register; all pins start as inputs so nothing
  // fights the board before software has configured the port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_direction_reg <= DGP_DIR_RESET;
    end else if (dir_wr_en) begin
      port_direction_reg <= wdata_low;
    end
  end

  // Output latch; written for every pin so a later turn-around
  // drives the last written level instead of a stale one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_level_reg <= DGP_DIR_RESET;
    end else if (level_wr_en) begin
      out_level_reg <= wdata_low;
    end
  end

  // Read view: inputs show the pin, outputs show the latch.
  // Output pins read the latch, not the pad, so a shorted pin
  // does not change what software believes it wrote.
  always_comb begin
    level_view = pick_view(port_direction_reg, out_level_reg, pif.pin_sensed);
  end

  // Read mux; upper byte and unmapped addresses return zero
  always_comb begin
    rdata_next = DGP_RDATA_IDLE;
    if (dir_sel) begin
      rdata_next = to_word(port_direction_reg);
    end else if (level_sel) begin
      rdata_next = to_word(level_view);
    end
  end

  // Answer flag, one cycle after the strobe for CPU or DMA alike
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
    end else if (core_ce) begin
      rvalid_reg <= rd_take;
    end
  end

  // Answer word; held until the next read so a slow master
  // may still pick it up after the flag has dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= DGP_RDATA_IDLE;
    end else if (rd_take) begin
      rdata_reg <= rdata_next;
    end
  end

  // Bus outputs straight from flops
  assign pb_rdata  = rdata_reg;
  assign pb_rvalid = rvalid_reg;

  // Register state handed to the pin stage
  assign pif.pin_direction_bit = port_direction_reg;
  assign pif.pin_out_level     = out_level_reg;

  // Pin stage: pad drivers and the two-flop input synchroniser.
  // Sensed levels lag the pads by two enabled cycles; software
  // polling faster than that sees the previous level.
  dgp_pin_stage u_stage (
    .clk     (core_clk),
    .rst_n   (rst_n),
    .ce      (core_ce),
    .pif     (pif),
    .pad_in  (gpio_in),
    .pad_out (gpio_out),
    .pad_oe  (gpio_oe)
  );
endmodule

// >>> tb/dgp_board.sv
`timescale 1ns/10ps
// Board side: driven pins follow the port, others show the board level
module dgp_board (
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin
);
  assign pin = (oe & out) | (~oe & ext);
endmodule

// >>> tb/dgp_asserts.sv
`timescale 1ns/10ps
module dgp_asserts
  import dgp_pkg::*;
(
  input wire logic        core_clk, rstn, core_ce, pb_wr, pb_rd, pb_rvalid,
  input wire logic [15:0] pb_addr, pb_wdata, pb_rdata,
  input wire logic [7:0]  gpio_out, gpio_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Reads taken only with the enable high
  wire rq = pb_rd && core_ce;
  a_read_answer: assert property (rq |=> pb_rvalid) else $error("no read answer");
  a_idle_valid: assert property (!rq |=> !pb_rvalid) else $error("stray valid");
  a_high_zero: assert property (pb_rvalid |-> pb_rdata[15:8] == 8'h00)
    else $error("upper bits set");
  a_dir_write: assert property (pb_wr && core_ce && pb_addr == DGP_DIR_ADDR
    |=> gpio_oe == 8'($past(pb_wdata))) else $error("direction not written");
  a_dir_read: assert property (rq && pb_addr == DGP_DIR_ADDR
    |=> pb_rdata == {8'h00, $past(gpio_oe)}) else $error("direction readback");
  a_out_read: assert property (rq && pb_addr == DGP_LEVEL_ADDR
    |=> ((pb_rdata[7:0] ^ $past(gpio_out)) & $past(gpio_oe)) == 8'h00)
    else $error("output latch readback");
  a_unmapped_zero: assert property (rq && pb_addr != DGP_DIR_ADDR
    && pb_addr != DGP_LEVEL_ADDR |=> pb_rdata == 16'h0000) else $error("unmapped data");
  c_read: cover property (rq ##1 pb_rvalid);
  c_dir_wr: cover property (pb_wr && pb_addr == DGP_DIR_ADDR);
  c_lvl_wr: cover property (pb_wr && pb_addr == DGP_LEVEL_ADDR);
endmodule
bind dgp_gpio_port dgp_asserts dgp_asserts_i (.core_clk(core_clk), .rstn(rstn),
  .core_ce(core_ce), .pb_wr(pb_wr), .pb_rd(pb_rd), .pb_rvalid(pb_rvalid), .pb_addr(pb_addr),
  .pb_wdata(pb_wdata), .pb_rdata(pb_rdata), .gpio_out(gpio_out), .gpio_oe(gpio_oe));

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
  import dgp_pkg::*;
  logic        core_clk = 0, rstn = 0, pb_wr = 0, pb_rd = 0, pb_rvalid, core_ce = 1;
  logic [15:0] pb_addr = 16'h0000, pb_wdata = 16'h0000, pb_rdata;
  logic [7:0]  ext = 8'hA5, pins, gpio_out, gpio_oe;
  int          err_count = 0, checks_done = 0;
  dgp_gpio_port dgp_gpio_port_i (.core_clk(core_clk), .core_ce(core_ce), .rstn(rstn),
    .pb_addr(pb_addr), .pb_wr(pb_wr), .pb_rd(pb_rd), .pb_wdata(pb_wdata), .pb_rdata(pb_rdata),
    .pb_rvalid(pb_rvalid), .gpio_in(pins), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  dgp_board dgp_board_i (.oe(gpio_oe), .out(gpio_out), .ext(ext), .pin(pins));
  initial forever #2.5 core_clk = ~core_clk;
  task stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Bus strobes are one-cycle pulses launched off the falling edge
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    pb_addr = a;
    pb_wdata = d;
    pb_wr = 1'b1;
    @(negedge core_clk);
    pb_wr = 1'b0;
  endtask
  task rdc(input logic [15:0] a, input logic [15:0] e);
    int i;
    @(negedge core_clk);
    pb_addr = a;
    pb_rd = 1'b1;
    @(negedge core_clk);
    pb_rd = 1'b0;
    for (i = 0; i < 4 && pb_rvalid !== 1'b1; i++) @(negedge core_clk);
    if (i == 4) err_count++;
    if (i == 4) stop_test();
    chk(pb_rdata, e);
  endtask
  task t_reset;
    rdc(DGP_DIR_ADDR, 16'h0000);
    rdc(DGP_LEVEL_ADDR, 16'h00A5);
  endtask
  task t_dir;
    wr(DGP_DIR_ADDR, 16'hFF5A);
    chk({8'h00, gpio_oe}, 16'h005A);
    rdc(DGP_DIR_ADDR, 16'h005A);
  endtask
  // Mixed pins: outputs show the latch, inputs the board level
  task t_out;
    wr(DGP_LEVEL_ADDR, 16'hFF3C);
    chk({8'h00, pins}, 16'h00BD);
    rdc(DGP_LEVEL_ADDR, 16'h00BD);
    rdc(16'h3402, 16'h0000);
  endtask
  // Board drops the input pins; wait out the two-flop lag
  task t_pin;
    @(negedge core_clk);
    ext = 8'h00;
    repeat (2) @(negedge core_clk);
    rdc(DGP_LEVEL_ADDR, 16'h0018);
  endtask
  // Enable low: a write is ignored
  task t_freeze;
    @(negedge core_clk);
    core_ce = 1'b0;
    wr(DGP_DIR_ADDR, 16'h00FF);
    chk({8'h00, gpio_oe}, 16'h005A);
    @(negedge core_clk);
    core_ce = 1'b1;
  endtask
  // Mid-run reset: pins back to inputs, data shows the board
  task t_rst;
    @(negedge core_clk);
    ext = 8'h3C;
    rstn = 1'b0;
    @(negedge core_clk);
    chk({8'h00, gpio_oe}, 16'h0000);
    chk({8'h00, pins}, 16'h003C);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    rdc(DGP_DIR_ADDR, 16'h0000);
    rdc(DGP_LEVEL_ADDR, 16'h003C);
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    t_reset();
    t_dir();
    t_out();
    t_pin();
    t_freeze();
    t_rst();
    stop_test();
  end
endmodule
